//--- src/ddswp_pkg.sv
// package for the serial write port host controller
`default_nettype none
package ddswp_pkg;
	localparam int WORD_BITS = 16;
	localparam int BYTE_BITS = 8;
	localparam int CTRL_MSB = 15;
	localparam int CTRL_LSB = 12;
	localparam int ADDR_MSB = 11;
	localparam int ADDR_LSB = 8;
	localparam int DATA_MSB = 7;
	localparam int DATA_LSB = 0;
	localparam int CLK_PERIOD_PS = 4000;
	localparam int SCLK_MAX_MHZ = 20;
	localparam int SCLK_MIN_PERIOD_PS = 1000000 / SCLK_MAX_MHZ;
	localparam int SCLK_HALF_CYC =
		(SCLK_MIN_PERIOD_PS / 2 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int GAP_CYC = 4;
	localparam int LEAD_CYC = 2;

	typedef enum logic [2:0] {
		DDSWP_IDLE,
		DDSWP_LEAD,
		DDSWP_HIGH,
		DDSWP_LOW,
		DDSWP_GAP,
		DDSWP_TAIL
	} ddswp_state_e;

	typedef struct packed {
		logic [3:0] ctrl;
		logic [3:0] addr;
		logic [7:0] data;
	} ddswp_word_s;

	typedef struct packed {
		logic frame_strobe_n;
		logic sclk;
		logic serial_data_in;
	} ddswp_pins_s;

	localparam ddswp_pins_s PINS_RST = '{frame_strobe_n: 1'b1, sclk: 1'b1,
		serial_data_in: 1'b0};
endpackage
`default_nettype wire

//--- src/ddswp_host.sv
// host controller that writes 16-bit words into the serial write port
`default_nettype none
module ddswp_host
	import ddswp_pkg::*;
#(
	parameter int HALF_CYC = SCLK_HALF_CYC
)(
	input  wire logic        clk,
	input  wire logic        rstn,
	input  wire logic        req_valid,
	input  wire ddswp_word_s req_word,
	input  wire logic        byte_mode,
	output logic             req_ready,
	output logic             frame_strobe_n,
	output logic             sclk,
	output logic             serial_data_in,
	output logic             word_done
);
	localparam int CW = 8;

	// cnt is CW bits wide, so a longer half period cannot be counted
	if (HALF_CYC < SCLK_HALF_CYC || HALF_CYC > (1 << CW) - 1)
	begin
		$error("HALF_CYC outside servable range");
	end

	typedef struct packed {
		ddswp_state_e state;
		ddswp_pins_s  pins;
		logic [15:0]  shreg;
		logic [4:0]   bits;
		logic [CW-1:0] cnt;
		logic         byte_mode;
		logic         ready;
		logic         done;
	} ddswp_regs_s;

	ddswp_regs_s st_ff;
	ddswp_regs_s nxt_st;

	always_comb
	begin
		nxt_st = st_ff;
		nxt_st.done = 1'b0;
		unique case (st_ff.state)
			DDSWP_IDLE:
			begin
				nxt_st.pins.sclk = 1'b1;
				if (req_valid && st_ff.ready)
				begin
					nxt_st.shreg = req_word;
					nxt_st.byte_mode = byte_mode;
					nxt_st.bits = 5'(WORD_BITS);
					nxt_st.ready = 1'b0;
					nxt_st.pins.frame_strobe_n = 1'b0;
					nxt_st.pins.serial_data_in = req_word[CTRL_MSB];
					nxt_st.cnt = CW'(LEAD_CYC);
					nxt_st.state = DDSWP_LEAD;
				end
			end
			DDSWP_LEAD, DDSWP_GAP:
			begin
				if (st_ff.cnt <= 1)
				begin
					nxt_st.cnt = CW'(HALF_CYC);
					nxt_st.state = DDSWP_HIGH;
				end
				else
					nxt_st.cnt = st_ff.cnt - 1'b1;
			end
			DDSWP_HIGH:
			begin
				if (st_ff.cnt <= 1)
				begin
					nxt_st.pins.sclk = 1'b0;
					nxt_st.bits = st_ff.bits - 1'b1;
					nxt_st.shreg = {st_ff.shreg[14:0], 1'b0};
					nxt_st.cnt = CW'(HALF_CYC);
					nxt_st.state = DDSWP_LOW;
				end
				else
					nxt_st.cnt = st_ff.cnt - 1'b1;
			end
			DDSWP_LOW:
			begin
				if (st_ff.cnt <= 1)
				begin
					nxt_st.pins.sclk = 1'b1;
					nxt_st.pins.serial_data_in = st_ff.shreg[WORD_BITS-1];
					nxt_st.cnt = CW'(HALF_CYC);
					if (st_ff.bits == 0)
						nxt_st.state = DDSWP_TAIL;
					else if (st_ff.byte_mode && st_ff.bits == 5'(BYTE_BITS))
					begin
						nxt_st.cnt = CW'(GAP_CYC);
						nxt_st.state = DDSWP_GAP;
					end
					else
						nxt_st.state = DDSWP_HIGH;
				end
				else
					nxt_st.cnt = st_ff.cnt - 1'b1;
			end
			DDSWP_TAIL:
			begin
				if (st_ff.cnt <= 1)
				begin
					nxt_st.pins.frame_strobe_n = 1'b1;
					nxt_st.done = 1'b1;
					nxt_st.ready = 1'b1;
					nxt_st.state = DDSWP_IDLE;
				end
				else
					nxt_st.cnt = st_ff.cnt - 1'b1;
			end
			default:
				nxt_st.state = DDSWP_IDLE;
		endcase
	end

	// one state register keeps every output straight from a flop
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
			st_ff <= '{state: DDSWP_IDLE, pins: PINS_RST, shreg: '0, bits: '0,
				cnt: '0, byte_mode: 1'b0, ready: 1'b1, done: 1'b0};
		else
			st_ff <= nxt_st;
	end

	assign req_ready      = st_ff.ready;
	assign frame_strobe_n = st_ff.pins.frame_strobe_n;
	assign sclk           = st_ff.pins.sclk;
	assign serial_data_in = st_ff.pins.serial_data_in;
	assign word_done      = st_ff.done;

	sequence s_fall;
		$fell(sclk);
	endsequence

	sequence s_rise;
		$rose(sclk);
	endsequence

	sequence s_take;
		req_valid && req_ready;
	endsequence

	// lead keeps the first clock edge clear of the frame's falling edge
	sequence s_lead_hold;
		(!frame_strobe_n && sclk) [*2];
	endsequence

	sequence s_gap_enter;
		$rose(st_ff.state == DDSWP_GAP);
	endsequence

	a_frame_low_fall: assert property (@(posedge clk) disable iff (!rstn)
		s_fall |-> !frame_strobe_n) else $error("clock fell outside frame");

	a_lead_frame: assert property (@(posedge clk) disable iff (!rstn)
		s_take |=> s_lead_hold) else $error("frame lead wrong");

	a_clk_idle_high: assert property (@(posedge clk) disable iff (!rstn)
		frame_strobe_n |-> sclk) else $error("clock not idle high");

	a_gap_high: assert property (@(posedge clk) disable iff (!rstn)
		st_ff.state == DDSWP_GAP |-> sclk && !frame_strobe_n) else $error("gap wrong");

	a_gap_len: assert property (@(posedge clk) disable iff (!rstn)
		s_gap_enter |-> (sclk && !frame_strobe_n) [*4]) else $error("gap too short");

	a_gap_count: assert property (@(posedge clk) disable iff (!rstn)
		s_gap_enter |-> st_ff.bits == 5'(BYTE_BITS)) else $error("gap not after eight bits");

	a_data_stable: assert property (@(posedge clk) disable iff (!rstn)
		s_fall |-> $stable(serial_data_in)) else $error("data moved at fall");

	// data may only move while the device is not sampling it
	a_data_change: assert property (@(posedge clk) disable iff (!rstn)
		$changed(serial_data_in) |-> $rose(sclk) || $fell(frame_strobe_n))
		else $error("data moved off a rising edge");

	// 20 MHz ceiling: each clock phase lasts at least seven system clocks
	a_low_width: assert property (@(posedge clk) disable iff (!rstn)
		s_fall |-> !sclk [*7]) else $error("clock low too short");

	a_high_width: assert property (@(posedge clk) disable iff (!rstn)
		s_rise |-> sclk [*7]) else $error("clock high too short");

	a_done_frame: assert property (@(posedge clk) disable iff (!rstn)
		$rose(frame_strobe_n) |-> word_done && st_ff.bits == 0) else $error("frame rose early");

	a_done_pulse: assert property (@(posedge clk) disable iff (!rstn)
		word_done |=> !word_done) else $error("done longer than one cycle");

	// one word per frame: no request is taken while a frame is open
	a_ready_busy: assert property (@(posedge clk) disable iff (!rstn)
		!frame_strobe_n |-> !req_ready) else $error("ready during frame");

	a_idle_ready: assert property (@(posedge clk) disable iff (!rstn)
		st_ff.state == DDSWP_IDLE |-> req_ready) else $error("idle but not ready");

	a_first_msb: assert property (@(posedge clk) disable iff (!rstn)
		s_take |=> serial_data_in == $past(req_word[CTRL_MSB])) else $error("first bit not msb");
endmodule
`default_nettype wire

//--- test/ddswp_dev_model.sv
// behavioural model of the device's serial write port
`default_nettype none
module ddswp_dev_model
	import ddswp_pkg::*;
(
	input  wire logic  frame_strobe_n,
	input  wire logic  sclk,
	input  wire logic  serial_data_in,
	output var  logic [15:0] got_word,
	output var  int    n_fall
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [15:0] sh;
	// one process owns the count: frame start clears it, falls in a frame add
	always @(negedge frame_strobe_n or negedge sclk)
	begin
		if (frame_strobe_n === 1'b0 && sclk === 1'b1)
			n_fall = 0;
		else if (frame_strobe_n === 1'b0)
		begin
			sh = {sh[14:0], serial_data_in};
			n_fall = n_fall + 1;
			if (n_fall == WORD_BITS)
				got_word = sh;
		end
	end
endmodule
`default_nettype wire

//--- test/ddswp_host_tb_top.sv
// self-checking bench for the serial write port host
`default_nettype none
module ddswp_host_tb_top;
	import ddswp_pkg::*;
	timeunit 1ns;
	timeprecision 1ps;
	logic        clk = 0, rstn = 0, req_valid = 0, byte_mode = 0;
	ddswp_word_s req_word = '0;
	logic        req_ready, frame_strobe_n, sclk, serial_data_in, word_done;
	logic [15:0] got_word;
	int          n_fall, miscompares = 0, n_compared = 0;
	always #2 clk = ~clk;
	ddswp_host u_ddswp_host (.clk(clk), .rstn(rstn), .req_valid(req_valid),
		.req_word(req_word), .byte_mode(byte_mode), .req_ready(req_ready),
		.frame_strobe_n(frame_strobe_n), .sclk(sclk),
		.serial_data_in(serial_data_in), .word_done(word_done));
	ddswp_dev_model u_ddswp_dev_model (.frame_strobe_n(frame_strobe_n),
		.sclk(sclk), .serial_data_in(serial_data_in), .got_word(got_word),
		.n_fall(n_fall));
	task automatic chk(input logic [15:0] e, input logic [15:0] a);
		n_compared++;
		if (a !== e)
		begin
			miscompares++;
			$display("ERROR t=%0t exp=%h act=%h", $time, e, a);
		end
	endtask
	task automatic stop_test;
		$display("compared %0d miscompares %0d", n_compared, miscompares);
		if (miscompares == 0 && n_compared > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	task automatic send(input logic [15:0] w, input logic m);
		int i;
		int n_exp;
		n_exp = LEAD_CYC + (2 * WORD_BITS + 1) * SCLK_HALF_CYC + (m ? GAP_CYC : 0);
		@(negedge clk);
		req_word = w;
		byte_mode = m;
		req_valid = 1'b1;
		do @(posedge clk); while (req_ready !== 1'b1);
		@(negedge clk);
		req_valid = 1'b0;
		chk(16'h0000, {15'h0, req_ready});
		// bounded wait: i ends at the cycles the frame stayed low
		for (i = 0; i < 2000 && word_done !== 1'b1; i++)
			@(negedge clk);
		chk(w, got_word);
		chk(16'h0010, 16'(n_fall));
		chk(16'h0007, {13'h0, req_ready, sclk, frame_strobe_n});
		chk(16'(n_exp), 16'(i));
	endtask
	task automatic t_word;
		send(16'h8001, 1'b0);
		send(16'hA5C3, 1'b0);
		send(16'hFFFF, 1'b0);
		$display("word mode test done");
	endtask
	task automatic t_byte;
		// back to back with a mode change in between
		send(16'h1234, 1'b1);
		send(16'hCDEF, 1'b1);
		send(16'h0F70, 1'b0);
		$display("byte mode test done");
	endtask
	initial
	begin
		#50000;
		miscompares++;
		stop_test();
	end
	initial
	begin
		repeat (12) @(posedge clk);
		@(negedge clk);
		rstn = 1'b1;
		t_word();
		t_byte();
		stop_test();
	end
endmodule
`default_nettype wire
